//--- hw/srsb_status.sv
// Service request status byte with request generation and data output start.
`timescale 1ns/1ns
`default_nettype none
module srsb_status #(
   parameter int unsigned VOLT_W = srsb_pkg::VOLT_W,
   parameter int unsigned CHAN_W = srsb_pkg::CHAN_W
) (
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire srsb_pkg::srsb_event_type  evt,
   input  wire srsb_pkg::srsb_cond_type   cond,
   input  wire logic signed [VOLT_W-1:0]  src_volt_mv,
   input  wire logic [CHAN_W-1:0]         trig_chan,
   input  wire logic                      serial_poll,
   input  wire logic                      device_clear,
   input  wire logic                      dout_done,
   output var  logic [7:0]                status_byte,
   output var  logic [7:0]                poll_byte_q,
   output var  logic                      srq,
   output var  logic                      dr_en_q,
   output var  logic                      settings_init_q,
   output var  logic                      dout_start_q,
   output var  logic                      dout_all_q,
   output var  logic [CHAN_W-1:0]         dout_chan_q,
   output var  logic                      dout_busy
);

   // ------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------
   localparam logic signed [VOLT_W-1:0] LIM = VOLT_W'(srsb_pkg::LID_LIMIT_MV);

   logic [7:0]                  status_q;
   logic [7:0]                  flag_set;
   logic [7:0]                  flag_clr;
   logic [7:0]                  base_clr;
   logic                        high_volt;
   logic                        lid_hazard;
   logic                        busy_lvl;
   logic                        do_take;
   srsb_pkg::srsb_do_state_type do_state_q;
   srsb_pkg::srsb_do_state_type do_state_d;

   // ------------------------------------------------------------
   // Hazard detection.
   // ------------------------------------------------------------
   assign high_volt = (src_volt_mv > LIM) || (src_volt_mv < -LIM);
   assign lid_hazard = (cond.lid_open && cond.meas_running && high_volt) || // [RULE11]
                       (cond.user_mode && (cond.lid_open || cond.short_absent)); // [RULE12]
   assign busy_lvl = cond.meas_active || cond.cal_active;

   // ------------------------------------------------------------
   // Set and clear terms for each flag.
   // ------------------------------------------------------------
   always_comb begin
      base_clr = ({8{serial_poll}} & ~srsb_pkg::POLL_KEEP_MASK) | // [RULE15]
                 ({8{device_clear}} & ~srsb_pkg::DCLR_KEEP_MASK); // [RULE16]
      flag_set = 8'h00;
      flag_clr = base_clr;
      flag_set[srsb_pkg::BIT_DREADY] = evt.data_complete; // [RULE3]
      flag_clr[srsb_pkg::BIT_DREADY] = base_clr[srsb_pkg::BIT_DREADY] | evt.xfer_start |
                                       evt.buffer_clear | dout_start_q; // [RULE4]
      flag_set[srsb_pkg::BIT_SYNTAX] = evt.syntax_err | lid_hazard; // [RULE5] [RULE11] [RULE12]
      flag_set[srsb_pkg::BIT_END] = evt.selftest_done | evt.plot_done |
                                    evt.print_done; // [RULE6]
      flag_set[srsb_pkg::BIT_ILLEGAL] = evt.illegal_prog |
                                        evt.source_monitor_unit_shutdown; // [RULE7] [RULE13]
      flag_set[srsb_pkg::BIT_BUSY] = busy_lvl; // [RULE8]
      flag_clr[srsb_pkg::BIT_BUSY] = !busy_lvl; // [RULE8]
      flag_set[srsb_pkg::BIT_STFAIL] = evt.selftest_fail | evt.power_loss_reset; // [RULE10] [RULE14]
      flag_clr[srsb_pkg::BIT_STFAIL] = base_clr[srsb_pkg::BIT_STFAIL] |
                                       evt.selftest_pass; // [RULE10]
      flag_set[srsb_pkg::BIT_EMERG] = lid_hazard | evt.source_monitor_unit_shutdown |
                                      evt.power_loss_reset; // [RULE11] [RULE13] [RULE14]
      flag_set[srsb_pkg::BIT_RQS] = (|(flag_set & srsb_pkg::RQS_SRC_MASK)) | // [RULE1] [RULE9]
                                    (evt.data_complete & dr_en_q); // [RULE2]
   end

   // ------------------------------------------------------------
   // Flag cells.
   // ------------------------------------------------------------
   for (genvar i = 0; i < srsb_pkg::STATUS_W; i++) begin : g_flag
      srsb_flag u_flag (
         .mclk    (mclk),
         .sys_rst (sys_rst),
         .set     (flag_set[i]),
         .clr     (flag_clr[i]),
         .q       (status_q[i])
      );
   end

   assign status_byte = status_q; // [RULE20]
   assign srq = status_q[srsb_pkg::BIT_RQS]; // [RULE1]

   // ------------------------------------------------------------
   // Serial poll answer, captured before the flags clear.
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         poll_byte_q <= srsb_pkg::STATUS_RESET;
      end else if (serial_poll) begin
         poll_byte_q <= status_q; // [RULE17]
      end
   end

   // ------------------------------------------------------------
   // Data ready request enable and control settings.
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dr_en_q <= srsb_pkg::DR_EN_RESET;
      end else if (device_clear) begin
         dr_en_q <= srsb_pkg::DR_EN_RESET; // [RULE19]
      end else if (evt.dr_enable) begin
         dr_en_q <= 1'b1; // [RULE2]
      end else if (evt.dr_disable) begin
         dr_en_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         settings_init_q <= 1'b0;
      end else begin
         settings_init_q <= device_clear; // [RULE19]
      end
   end

   // ------------------------------------------------------------
   // Data output sequencing.
   // ------------------------------------------------------------
   assign do_take = evt.data_out_cmd && (do_state_q == srsb_pkg::DO_IDLE);
   assign dout_busy = (do_state_q == srsb_pkg::DO_SEND);

   always_comb begin
      do_state_d = do_state_q;
      case (do_state_q)
         srsb_pkg::DO_IDLE: begin
            if (evt.data_out_cmd) begin
               do_state_d = srsb_pkg::DO_SEND;
            end
         end
         srsb_pkg::DO_SEND: begin
            if (dout_done || device_clear) begin
               do_state_d = srsb_pkg::DO_IDLE;
            end
         end
         default: begin
            do_state_d = srsb_pkg::DO_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         do_state_q <= srsb_pkg::DO_IDLE;
      end else begin
         do_state_q <= do_state_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dout_start_q <= 1'b0;
         dout_all_q   <= 1'b0;
         dout_chan_q  <= '0;
      end else begin
         dout_start_q <= do_take; // [RULE18]
         if (do_take) begin
            dout_all_q  <= !cond.user_mode; // [RULE18]
            dout_chan_q <= trig_chan; // [RULE18]
         end
      end
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   AST_RQS_FROM_SRC: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
      (|(flag_set & srsb_pkg::RQS_SRC_MASK)) |=> srq && status_q[srsb_pkg::BIT_RQS])
      else $error("Requesting flag did not raise the service request.");

   AST_DR_GATED: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
      (evt.data_complete && !srq && ((flag_set & srsb_pkg::RQS_SRC_MASK) == 8'h00))
      |=> (srq == $past(dr_en_q)))
      else $error("Data ready request did not follow its enable.");

   AST_DR_SET: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE3]
      evt.data_complete |=> status_q[srsb_pkg::BIT_DREADY])
      else $error("Data ready not set after complete data.");

   AST_DR_CLR: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4]
      ((evt.xfer_start || evt.buffer_clear || dout_start_q) && !evt.data_complete)
      |=> !status_q[srsb_pkg::BIT_DREADY])
      else $error("Data ready not cleared by transfer or buffer clear.");

   AST_SYNTAX_SET: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
      evt.syntax_err |=> status_q[srsb_pkg::BIT_SYNTAX] && srq)
      else $error("Syntax error flag not set.");

   AST_END_SET: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
      (evt.selftest_done || evt.plot_done || evt.print_done)
      |=> status_q[srsb_pkg::BIT_END] && srq)
      else $error("End flag not set on completion.");

   AST_ILLEGAL_SET: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE7]
      evt.illegal_prog |=> status_q[srsb_pkg::BIT_ILLEGAL])
      else $error("Illegal program flag not set.");

   AST_BUSY_FOLLOW: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE8]
      ##1 (status_q[srsb_pkg::BIT_BUSY] == $past(busy_lvl)))
      else $error("Busy flag does not follow activity.");

   AST_BUSY_NO_RQS: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE9]
      ($rose(busy_lvl) && !srq && !evt.data_complete &&
       ((flag_set & srsb_pkg::RQS_SRC_MASK) == 8'h00)) |=> !srq)
      else $error("Busy raised a service request.");

   AST_STFAIL: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE10]
      (status_q[srsb_pkg::BIT_STFAIL] && !evt.selftest_pass && !serial_poll && !device_clear)
      |=> status_q[srsb_pkg::BIT_STFAIL])
      else $error("Self-test fail cleared without a pass.");

   AST_LID_HV: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
      (cond.lid_open && cond.meas_running && high_volt)
      |=> status_q[srsb_pkg::BIT_EMERG] && status_q[srsb_pkg::BIT_SYNTAX])
      else $error("Lid hazard not flagged.");

   AST_LID_USER: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE12]
      (cond.user_mode && (cond.lid_open || cond.short_absent))
      |=> status_q[srsb_pkg::BIT_EMERG] && status_q[srsb_pkg::BIT_SYNTAX])
      else $error("User mode lid hazard not flagged.");

   AST_SHUTDOWN: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE13]
      evt.source_monitor_unit_shutdown
      |=> status_q[srsb_pkg::BIT_EMERG] && status_q[srsb_pkg::BIT_ILLEGAL])
      else $error("Source shutdown not flagged.");

   AST_PWR_LOSS: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE14]
      evt.power_loss_reset |=> status_q[srsb_pkg::BIT_EMERG] && status_q[srsb_pkg::BIT_STFAIL])
      else $error("Power loss reset not flagged.");

   AST_POLL_CLR: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE15]
      (serial_poll && (flag_set & ~srsb_pkg::POLL_KEEP_MASK) == 8'h00)
      |=> ((status_q & ~srsb_pkg::POLL_KEEP_MASK) == 8'h00) && (poll_byte_q == $past(status_q)))
      else $error("Serial poll did not clear the flags.");

   AST_DCLR_CLR: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE16]
      (device_clear && !serial_poll && (flag_set & ~srsb_pkg::DCLR_KEEP_MASK) == 8'h00 &&
       !evt.xfer_start && !evt.buffer_clear && !dout_start_q && !evt.data_complete)
      |=> ((status_q & ~srsb_pkg::DCLR_KEEP_MASK) == 8'h00) &&
          (status_q[srsb_pkg::BIT_DREADY] == $past(status_q[srsb_pkg::BIT_DREADY])))
      else $error("Device clear touched the wrong flags.");

   AST_DOUT: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE18]
      do_take |=> dout_start_q && dout_busy && (dout_all_q == !$past(cond.user_mode))
      ##1 !dout_start_q)
      else $error("Data output did not start correctly.");

   AST_DCLR_INIT: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE19]
      device_clear |=> settings_init_q && (dr_en_q == srsb_pkg::DR_EN_RESET))
      else $error("Device clear did not restore settings.");

   // ------------------------------------------------------------
   // Service request, request enable, settings pulse and data output sequencing checks.
   // ------------------------------------------------------------
   AST_RQS_HOLD: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
      (srq && !serial_poll && !device_clear)
      |=> srq)
      else $error("Service request dropped without a poll or clear.");

   AST_RQS_ONLY_SRC: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE9]
      (!srq && ((flag_set & srsb_pkg::RQS_SRC_MASK) == 8'h00) &&
       !(evt.data_complete && dr_en_q))
      |=> !srq)
      else $error("Service request raised without a requesting flag.");

   AST_DR_EN_SET: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
      (evt.dr_enable && !device_clear)
      |=> dr_en_q)
      else $error("Data ready request enable not taken.");

   AST_DR_EN_CLR: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
      (evt.dr_disable && !evt.dr_enable)
      |=> !dr_en_q)
      else $error("Data ready request disable not taken.");

   AST_SETTINGS_PULSE: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE19]
      !device_clear
      |=> !settings_init_q)
      else $error("Settings restore pulsed without a device clear.");

   AST_DOUT_REFUSED: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE18]
      (evt.data_out_cmd && dout_busy)
      |=> !dout_start_q)
      else $error("Data output command taken while busy.");

   AST_DOUT_CHAN: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE18]
      do_take
      |=> (dout_chan_q == $past(trig_chan)))
      else $error("Triggered channel not captured.");

   AST_DOUT_END: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE18] [RULE19]
      (dout_busy && (dout_done || device_clear))
      |=> !dout_busy)
      else $error("Data output did not end.");

endmodule
`default_nettype wire

//--- hw/srsb_pkg.sv
// Constants, types and field layout of the service request status byte.
// Behaviour
// [RULE1] Requesting flags set RQS and raise SRQ.
// [RULE2] Data ready requests only when enabled.
// [RULE3] Complete measurement data sets data ready.
// [RULE4] Transfer start or buffer clear clears ready.
// [RULE5] Malformed program code sets syntax error.
// [RULE6] Self-test, plot, print completion set end.
// [RULE7] Invalid program sets illegal program flag.
// [RULE8] Busy follows measurement or calibration activity.
// [RULE9] Busy never requests service.
// [RULE10] Self-test fail cleared only by passing; serial poll and device clear also clear it.
// [RULE11] Lid open above 42 volts: emergency, syntax.
// [RULE12] User mode lid or connector: emergency, syntax.
// [RULE13] Source shutdown sets emergency and illegal program.
// [RULE14] Power loss reset: emergency and self-test fail.
// [RULE15] Serial poll clears all except busy.
// [RULE16] Device clear keeps data ready and busy.
// [RULE17] Controller polls for data ready before output.
// [RULE18] Output command sends all or triggered channel.
// [RULE19] Device clear restores initial control settings.
// [RULE20] Flags one to eight map bits zero-seven.
package srsb_pkg;

   // ------------------------------------------------------------
   // Status byte field positions.
   // ------------------------------------------------------------
   localparam int unsigned BIT_DREADY  = 0;
   localparam int unsigned BIT_SYNTAX  = 1;
   localparam int unsigned BIT_END     = 2;
   localparam int unsigned BIT_ILLEGAL = 3;
   localparam int unsigned BIT_BUSY    = 4;
   localparam int unsigned BIT_STFAIL  = 5;
   localparam int unsigned BIT_RQS     = 6;
   localparam int unsigned BIT_EMERG   = 7;
   localparam int unsigned STATUS_W    = 8;

   // ------------------------------------------------------------
   // Reset values and masks.
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] RQS_SRC_MASK   = 8'hae;
   localparam logic [7:0] POLL_KEEP_MASK = 8'h10;
   localparam logic [7:0] DCLR_KEEP_MASK = 8'h11;
   localparam logic       DR_EN_RESET    = 1'b0;

   // ------------------------------------------------------------
   // Output voltage limit for the lid check, in millivolts.
   // ------------------------------------------------------------
   localparam int unsigned   VOLT_W       = 20;
   localparam int unsigned   LID_LIMIT_V  = 42;
   localparam logic signed [19:0] LID_LIMIT_MV = 20'(LID_LIMIT_V * 1000);
   localparam int unsigned   CHAN_W       = 3;

   // ------------------------------------------------------------
   // Carriers.
   // ------------------------------------------------------------
   typedef struct packed {
      logic data_complete;
      logic xfer_start;
      logic buffer_clear;
      logic syntax_err;
      logic selftest_done;
      logic selftest_pass;
      logic selftest_fail;
      logic plot_done;
      logic print_done;
      logic illegal_prog;
      logic source_monitor_unit_shutdown;
      logic power_loss_reset;
      logic dr_enable;
      logic dr_disable;
      logic data_out_cmd;
   } srsb_event_type;

   typedef struct packed {
      logic meas_active;
      logic cal_active;
      logic meas_running;
      logic user_mode;
      logic lid_open;
      logic short_absent;
   } srsb_cond_type;

   typedef enum logic [1:0] {
      DO_IDLE = 2'b01,
      DO_SEND = 2'b10
   } srsb_do_state_type;

endpackage

//--- hw/srsb_flag.sv
// One status flag that holds its value, with a set that wins over a clear.
`timescale 1ns/1ns
`default_nettype none
module srsb_flag (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic set,
   input  wire logic clr,
   output var  logic q
);

   // ------------------------------------------------------------
   // Flag storage.
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clr) begin
         q <= 1'b0;
      end
   end

endmodule
`default_nettype wire

//--- testbench/srsb_ctrl_model.sv
// Bus controller model that serial-polls the status byte.
`timescale 1ns/1ns
`default_nettype none
module srsb_ctrl_model (
   input  wire logic       mclk,
   input  wire logic [7:0] poll_byte_q,
   output var  logic       serial_poll
);
   initial serial_poll = 1'b0;

   // Pulses one serial poll and returns the byte captured by the device.
   task automatic do_poll(output logic [7:0] b);
      @(posedge mclk);
      serial_poll <= 1'b1;
      @(posedge mclk);
      serial_poll <= 1'b0;
      #1;
      b = poll_byte_q;
   endtask

   // Polls repeatedly until data ready reads one, within a bound.
   task automatic wait_ready(output logic ok);
      logic [7:0] b;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         do_poll(b);
         ok = (b[srsb_pkg::BIT_DREADY] === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking testbench of the service request status byte.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                     mclk, sys_rst, serial_poll, device_clear, dout_done;
   srsb_pkg::srsb_event_type evt;
   srsb_pkg::srsb_cond_type  cond;
   logic signed [19:0]       src_volt_mv;
   logic [2:0]               trig_chan, dout_chan_q;
   logic [7:0]               status_byte, poll_byte_q;
   logic                     srq, dr_en_q, settings_init_q, dout_start_q, dout_all_q, dout_busy;
   int                       bad_count, compares;

   srsb_status DUT (.mclk(mclk), .sys_rst(sys_rst), .evt(evt), .cond(cond),
      .src_volt_mv(src_volt_mv), .trig_chan(trig_chan), .serial_poll(serial_poll),
      .device_clear(device_clear), .dout_done(dout_done), .status_byte(status_byte),
      .poll_byte_q(poll_byte_q), .srq(srq), .dr_en_q(dr_en_q),
      .settings_init_q(settings_init_q), .dout_start_q(dout_start_q),
      .dout_all_q(dout_all_q), .dout_chan_q(dout_chan_q), .dout_busy(dout_busy));
   srsb_ctrl_model ctrl (.mclk(mclk), .poll_byte_q(poll_byte_q), .serial_poll(serial_poll));

   always #25 mclk = ~mclk;

   task automatic finish_test();
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic fire(srsb_pkg::srsb_event_type e);
      @(posedge mclk);
      evt <= e;
      @(posedge mclk);
      evt <= '0;
      #1;
   endtask

   task automatic fire_pos(int p);
      srsb_pkg::srsb_event_type e;
      e = '0;
      e[p] = 1'b1;
      fire(e);
   endtask

   task automatic cset(srsb_pkg::srsb_cond_type c, logic signed [19:0] v);
      @(posedge mclk);
      cond <= c;
      src_volt_mv <= v;
      @(posedge mclk);
      #1;
   endtask

   task automatic dclr();
      @(posedge mclk);
      device_clear <= 1'b1;
      @(posedge mclk);
      device_clear <= 1'b0;
      #1;
   endtask

   task automatic poll_chk(logic [7:0] exp, logic [7:0] after);
      logic [7:0] b;
      ctrl.do_poll(b);
      chk("poll_byte", exp, b);
      chk("status after poll", after, status_byte);
   endtask

   // --------------------------------------------------------------
   // Scenarios.
   // --------------------------------------------------------------
   task automatic t_syntax();
      chk("status at reset", 8'h00, status_byte);
      fire_pos(11);
      chk("syntax status", 8'h42, status_byte);
      chk("syntax srq", 8'h01, {7'h00, srq});
      poll_chk(8'h42, 8'h00);
   endtask

   // Plot, print, self-test done, illegal program, shutdown, power loss.
   task automatic t_table();
      int         pos [6] = '{7, 6, 10, 5, 4, 3};
      logic [7:0] exp [6] = '{8'h44, 8'h44, 8'h44, 8'h48, 8'hc8, 8'he0};
      for (int i = 0; i < 6; i++) begin
         fire_pos(pos[i]);
         chk("event status", exp[i], status_byte);
         chk("event srq", 8'h01, {7'h00, srq});
         poll_chk(exp[i], 8'h00);
      end
   endtask

   task automatic t_ready();
      fire_pos(2);
      fire_pos(1);
      fire_pos(14);
      chk("ready no enable", 8'h01, status_byte);
      fire_pos(12);
      chk("buffer clear", 8'h00, status_byte);
      fire_pos(2);
      chk("enable", 8'h01, {7'h00, dr_en_q});
      fire_pos(14);
      chk("ready enabled", 8'h41, status_byte);
      dclr();
      chk("device clear", 8'h01, status_byte);
      chk("settings init", 8'h01, {7'h00, settings_init_q});
      fire_pos(13);
      chk("transfer start", 8'h00, status_byte);
   endtask

   task automatic t_busy_stfail();
      srsb_pkg::srsb_cond_type c;
      c = '0;
      c.meas_active = 1'b1;
      cset(c, 20'sh0);
      chk("busy", 8'h10, status_byte);
      poll_chk(8'h10, 8'h10);
      dclr();
      chk("busy after clear", 8'h10, status_byte);
      cset('0, 20'sh0);
      chk("busy ended", 8'h00, status_byte);
      fire_pos(8);
      fire_pos(10);
      chk("fail kept", 8'h64, status_byte);
      fire_pos(9);
      chk("fail cleared", 8'h44, status_byte);
      poll_chk(8'h44, 8'h00);
   endtask

   task automatic t_lid();
      srsb_pkg::srsb_cond_type c;
      c = '0;
      c.meas_running = 1'b1;
      c.lid_open = 1'b1;
      cset(c, 20'sd42000);
      chk("lid at limit", 8'h00, status_byte);
      cset(c, -20'sd42001);
      chk("lid high volt", 8'hc2, status_byte);
      cset('0, 20'sh0);
      poll_chk(8'hc2, 8'h00);
      c = '0;
      c.user_mode = 1'b1;
      c.short_absent = 1'b1;
      cset(c, 20'sh0);
      chk("user connector", 8'hc2, status_byte);
      cset('0, 20'sh0);
      poll_chk(8'hc2, 8'h00);
   endtask

   task automatic t_dout();
      srsb_pkg::srsb_cond_type c;
      logic                    ok;
      fire_pos(14);
      ctrl.wait_ready(ok);
      chk("ready seen", 8'h01, {7'h00, ok});
      if (ok !== 1'b1) finish_test();
      fire_pos(0);
      chk("start all", 8'h07, {5'h00, dout_start_q, dout_all_q, dout_busy});
      fire_pos(0);
      chk("refused", 8'h01, {6'h00, dout_start_q, dout_busy});
      @(posedge mclk);
      dout_done <= 1'b1;
      @(posedge mclk);
      dout_done <= 1'b0;
      trig_chan <= 3'h5;
      #1;
      chk("done", 8'h00, {7'h00, dout_busy});
      c = '0;
      c.user_mode = 1'b1;
      cset(c, 20'sh0);
      fire_pos(0);
      chk("start chan", 8'h0a, {4'h0, dout_chan_q, dout_all_q});
      dclr();
      chk("clear aborts", 8'h00, {7'h00, dout_busy});
   endtask

   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      evt = '0;
      cond = '0;
      src_volt_mv = 20'sh0;
      trig_chan = 3'h0;
      device_clear = 1'b0;
      dout_done = 1'b0;
      bad_count = 0;
      compares = 0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      #1;
      t_syntax();
      t_table();
      t_ready();
      t_busy_stfail();
      t_lid();
      t_dout();
      finish_test();
   end
endmodule
`default_nettype wire
